// [rtl/pcs_defines.vh]
// Purpose: constants for the configuration record of the PCI target
// Assumes: doubleword-indexed access, byte enables active high
// Notes:   offsets are doubleword indices into the 256-byte record
`ifndef PCS_DEFINES_VH
`define PCS_DEFINES_VH

`define PCS_DW_ID         6'h00
`define PCS_DW_CMDSTAT    6'h01
`define PCS_DW_CLASS      6'h02
`define PCS_DW_HDR        6'h03
`define PCS_DW_INTLINE    6'h0f
`define PCS_DW_DEVSPEC    6'h10
`define PCS_CMD_IO        0
`define PCS_CMD_MEM       1
`define PCS_CMD_SNOOP     5
`define PCS_CMD_PARITY    6
`define PCS_CMD_STEP      7
`define PCS_CMD_SPECIAL   3
`define PCS_CMD_RW_MASK   16'h006b
`define PCS_STAT_ABORT    11
`define PCS_DEVSEL_FAST   2'h0
`define PCS_HDR_TYPE      8'h00
`define PCS_CLASS_VAL     24'h030000
`define PCS_REV_VAL       8'h00
`define PCS_INTLINE_MASK  8'h0f
`define PCS_SPEC_WORDS    48

`endif

// [rtl/pcs_spec_ram.v]
// Purpose: device-specific scratch words of the configuration record
// Assumes: one write port with byte enables, one read port
// Notes:   read data is registered, one cycle after the request
`default_nettype none

module pcs_spec_ram #(
  parameter DEPTH = 48,
  parameter AW    = 6
) (
  input  wire          clk,
  input  wire          nrst,
  input  wire          wr,
  input  wire [AW-1:0] addr,
  input  wire [3:0]    be,
  input  wire [31:0]   wdata,
  output reg  [31:0]   rdata
);

  reg [31:0] mem [0:DEPTH-1];
  genvar g;

  // Byte-lane writes, only enabled lanes change
  generate
    for (g = 0; g < 4; g = g + 1) begin : lane
      always @(posedge clk) begin
        if (wr && be[g]) begin
          mem[addr][8*g+7:8*g] <= wdata[8*g+7:8*g];
        end
      end
    end
  endgenerate

  // Registered read port
  always @(posedge clk) begin
    if (!nrst) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= mem[addr];
    end
  end

endmodule

`default_nettype wire

// [rtl/pcs_config_space.v]
// Purpose: 256-byte configuration record of a PCI graphics target
// Assumes: the bus engine decodes config cycles and hands over one
//          doubleword access at a time with byte enables
//          cfg_addr, cfg_wr, cfg_be and cfg_wdata are valid with cfg_req
//          byte enables of a read are ignored; the whole word returns
//          target_abort is a pulse from the same clock domain
// Notes:   answers one cycle after cfg_req, always, whatever command bits say
//          one access per cfg_req pulse; back-to-back pulses are fine
//          word map, doubleword index and byte offset:
//            0  (00h) device and vendor identity, read-only
//            1  (04h) command in the low half, status in the high half
//            2  (08h) class code and revision, read-only
//            3  (0ch) header type in byte 2, other bytes reserved
//            15 (3ch) interrupt line in byte 0, low nibble writable
//            16 to 63 (40h to ffh) device-specific scratch words
//          every other header word is reserved: reads zero, drops writes
//          writes to read-only words complete and are discarded
//          scratch words have no reset and read unknown until written
//          command bit 7 reads zero: no address stepping here
//          status bit 11 is the only status bit that can be set
// Behaviour
// - record is 256 bytes: 64-byte header then 192 device-specific bytes
// - configuration accesses answered always, even with command bits clear
// - writes with no effect complete normally and are discarded
// - reserved or unimplemented reads complete normally and return zero
// - device-specific registers live only at bytes 64 to 255
// - multi-byte fields store least significant byte at lowest address
// - first 16 header bytes use the common layout
// - vendor id, device id, command and status are implemented
// - supported header registers sit at their defined place
// - reads return the setting actually in use
// - command bits 1 and 0 gate memory and io response, reset cleared
// - status writes clear bits written as one only
// - header type reads zero: single function, standard layout
// - devsel timing bits read-only, fixed at fast
`default_nettype none
`include "pcs_defines.vh"

module pcs_config_space #(
  parameter [15:0] VENDOR_CODE = 16'h1234, // Arbitrary value
  parameter [15:0] DEVICE_CODE = 16'h5678, // Arbitrary value
  parameter        SPEC_WORDS  = `PCS_SPEC_WORDS
) (
  input  wire        clk,
  input  wire        nrst,
  input  wire        cfg_req,
  input  wire        cfg_wr,
  input  wire [5:0]  cfg_addr,
  input  wire [3:0]  cfg_be,
  input  wire [31:0] cfg_wdata,
  output reg         cfg_ack,
  output reg  [31:0] cfg_rdata,
  input  wire        target_abort,
  output wire        mem_enable,
  output wire        io_enable,
  output wire        palette_snoop,
  output wire        parity_resp,
  output wire        special_cycle,
  output wire [3:0]  int_line
);

  // Registers
  reg  [15:0] cmd;
  reg  [15:0] stat_abort;
  reg  [7:0]  intline;
  reg         spec_sel_q;
  reg  [31:0] hdr_rdata;

  // Decode and datapath nets
  wire [31:0] spec_rdata;
  wire        spec_hit;
  wire        wr_cmd;
  wire        wr_stat;
  wire [15:0] cmd_wmask;
  wire [15:0] stat_wdata;
  wire [15:0] stat_set;
  wire [15:0] stat_word;
  wire [15:0] next_cmd;
  reg  [7:0]  next_intline;
  reg  [31:0] hdr_q;
  wire [31:0] id_word;
  wire [31:0] cs_word;
  wire [31:0] cls_word;
  wire [31:0] type_word;
  wire [31:0] int_word;
  wire [2:0]  kind;
  wire        rd_req;
  wire        wr_req;
  wire        wr_int;
  wire        spec_wr;
  wire [5:0]  spec_addr;
  genvar      g;

  // Coarse classes of the 64 doubleword slots
  localparam [2:0] KIND_RSVD = 3'h0;
  localparam [2:0] KIND_ID   = 3'h1;
  localparam [2:0] KIND_CMD  = 3'h2;
  localparam [2:0] KIND_CLS  = 3'h3;
  localparam [2:0] KIND_HDR  = 3'h4;
  localparam [2:0] KIND_INT  = 3'h5;
  localparam [2:0] KIND_SPEC = 3'h6;

  // Byte-enable expansion for a 16-bit half of the doubleword
  function [15:0] be_mask16;
    input [1:0] be;
    begin
      be_mask16 = {{8{be[1]}}, {8{be[0]}}};
    end
  endfunction

  // Slot class of a doubleword index; shared by write and read decode
  function [2:0] word_kind;
    input [5:0] a;
    begin
      // Anything at or past the header boundary is scratch
      if (a >= `PCS_DW_DEVSPEC) begin
        word_kind = KIND_SPEC;
      end else begin
        // Header words by exact index, the rest reserved
        case (a)
          `PCS_DW_ID:      word_kind = KIND_ID;
          `PCS_DW_CMDSTAT: word_kind = KIND_CMD;
          `PCS_DW_CLASS:   word_kind = KIND_CLS;
          `PCS_DW_HDR:     word_kind = KIND_HDR;
          `PCS_DW_INTLINE: word_kind = KIND_INT;
          default:         word_kind = KIND_RSVD;
        endcase
      end
    end
  endfunction

  // Request qualifiers and slot decode, one access per cfg_req
  assign kind     = word_kind(cfg_addr);
  assign rd_req   = cfg_req && !cfg_wr;
  assign wr_req   = cfg_req && cfg_wr;
  assign spec_hit = (kind == KIND_SPEC);
  assign wr_cmd   = wr_req && (kind == KIND_CMD);
  assign wr_stat  = wr_cmd;
  assign wr_int   = wr_req && (kind == KIND_INT) && cfg_be[0];
  assign spec_wr  = wr_req && spec_hit;

  // Scratch index counts from the first device-specific word
  assign spec_addr = cfg_addr - `PCS_DW_DEVSPEC;

  // Byte-enable masks for the command and status halves
  assign cmd_wmask  = be_mask16(cfg_be[1:0]) & `PCS_CMD_RW_MASK;
  assign stat_wdata = cfg_wdata[31:16] & be_mask16(cfg_be[3:2]);
  assign stat_set   = {{15{1'b0}}, target_abort} << `PCS_STAT_ABORT;

  // Next command value, lane by lane; reserved bits never take data
  generate
    for (g = 0; g < 2; g = g + 1) begin : cmd_lane
      assign next_cmd[8*g+7:8*g] = wr_cmd ?
        ((cmd[8*g+7:8*g] & ~cmd_wmask[8*g+7:8*g]) |
         (cfg_wdata[8*g+7:8*g] & cmd_wmask[8*g+7:8*g])) :
        cmd[8*g+7:8*g];
    end
  endgenerate

  // Command register; cleared so no space answers before setup
  always @(posedge clk) begin
    if (!nrst) begin
      cmd <= 16'h0000;
    end else begin
      cmd <= next_cmd;
    end
  end

  // Status bits: hardware set beats a simultaneous write-one clear
  generate
    for (g = 0; g < 16; g = g + 1) begin : stat_bit
      if (g == `PCS_STAT_ABORT) begin : w1c
        always @(posedge clk) begin
          if (!nrst) begin
            stat_abort[g] <= 1'b0;
          end else if (stat_set[g]) begin
            stat_abort[g] <= 1'b1;
          end else if (wr_stat && stat_wdata[g]) begin
            stat_abort[g] <= 1'b0;
          end
        end
      end else begin : fixed
        // Unimplemented status bits are hardwired to zero
        always @(posedge clk) begin
          stat_abort[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Next interrupt line: low nibble writable, upper nibble reads zero
  always @* begin
    next_intline = intline;
    if (wr_int) begin
      next_intline = cfg_wdata[7:0] & `PCS_INTLINE_MASK;
    end
  end

  // Interrupt line register
  always @(posedge clk) begin
    if (!nrst) begin
      intline <= 8'h00;
    end else begin
      intline <= next_intline;
    end
  end

  // Device-specific scratch area, bytes 64 to 255
  // Scratch words hold no reset value; software sets them up
  pcs_spec_ram #(
    .DEPTH (SPEC_WORDS),
    .AW    (6)
  ) u_spec (
    .clk   (clk),
    .nrst  (nrst),
    .wr    (spec_wr),
    .addr  (spec_addr),
    .be    (cfg_be),
    .wdata (cfg_wdata),
    .rdata (spec_rdata)
  );

  // Header field words, least significant byte at the lowest address
  assign id_word   = {DEVICE_CODE, VENDOR_CODE};
  assign stat_word = {stat_abort[15:11], `PCS_DEVSEL_FAST, 9'h000};
  assign cs_word   = {stat_word, cmd};
  assign cls_word  = {`PCS_CLASS_VAL, `PCS_REV_VAL};
  assign type_word = {8'h00, `PCS_HDR_TYPE, 16'h0000};
  assign int_word  = {24'h000000, intline};

  // Header read mux; live register values, never shadow copies
  always @* begin
    hdr_rdata = 32'h0000_0000;
    case (kind)
      KIND_ID: begin
        hdr_rdata = id_word;
      end
      KIND_CMD: begin
        hdr_rdata = cs_word;
      end
      KIND_CLS: begin
        hdr_rdata = cls_word;
      end
      KIND_HDR: begin
        hdr_rdata = type_word;
      end
      KIND_INT: begin
        hdr_rdata = int_word;
      end
      default: begin
        hdr_rdata = 32'h0000_0000;
      end
    endcase
  end

  // Answer every request one cycle later, enables never gate it
  always @(posedge clk) begin
    if (!nrst) begin
      cfg_ack <= 1'b0;
    end else begin
      cfg_ack <= cfg_req;
    end
  end

  // Remembers that the answer must come from the scratch ram
  always @(posedge clk) begin
    if (!nrst) begin
      spec_sel_q <= 1'b0;
    end else begin
      spec_sel_q <= rd_req && spec_hit;
    end
  end

  // Header read data register; writes leave zero behind, harmlessly
  always @(posedge clk) begin
    if (!nrst) begin
      hdr_q <= 32'h0000_0000;
    end else if (rd_req && !spec_hit) begin
      hdr_q <= hdr_rdata;
    end else begin
      hdr_q <= 32'h0000_0000;
    end
  end

  // Answer data picks between two registered sources
  always @* begin
    if (spec_sel_q) begin
      cfg_rdata = spec_rdata;
    end else begin
      cfg_rdata = hdr_q;
    end
  end

  // Space enables straight from the command bits
  assign mem_enable    = cmd[`PCS_CMD_MEM];
  assign io_enable     = cmd[`PCS_CMD_IO];
  // Other command bits go to the rest of the chip as they stand
  assign palette_snoop = cmd[`PCS_CMD_SNOOP];
  assign parity_resp   = cmd[`PCS_CMD_PARITY];
  assign special_cycle = cmd[`PCS_CMD_SPECIAL];
  // Only the low nibble of the interrupt line is wired out
  assign int_line      = intline[3:0];

endmodule

`default_nettype wire

// [dv/pcs_props.sv]
// Purpose: port checks of the config record
// Assumes: one access per cfg_req
// Notes:   answer lands one cycle on
`default_nettype none
`include "pcs_defines.vh"
module pcs_props (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        cfg_req,
  input wire logic        cfg_wr,
  input wire logic [5:0]  cfg_addr,
  input wire logic        cfg_ack,
  input wire logic [31:0] cfg_rdata,
  input wire logic        mem_enable,
  input wire logic        io_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Read request of one word
  sequence s_rd(logic [5:0] a); cfg_req && !cfg_wr && cfg_addr == a; endsequence
  a_ack_next: assert property (cfg_req |=> cfg_ack) else $error("no answer");
  a_ack_cause: assert property (cfg_ack |-> $past(cfg_req)) else $error("stray answer");
  a_rsvd_zero: assert property (cfg_req && !cfg_wr && cfg_addr > 6'h03 && cfg_addr < 6'h10 &&
    cfg_addr != 6'h0f |=> cfg_rdata == 32'h0) else $error("reserved word");
  a_hdr_type: assert property (s_rd(`PCS_DW_HDR) |=>
    cfg_rdata[23:16] == 8'h00) else $error("header type");
  a_devsel_fast: assert property (s_rd(`PCS_DW_CMDSTAT) |=>
    cfg_rdata[26:25] == 2'h0) else $error("devsel timing");
  a_cmd_mirror: assert property (s_rd(`PCS_DW_CMDSTAT) |=>
    cfg_rdata[1:0] == {mem_enable, io_enable}) else $error("command mirror");
  a_cmd_rsvd: assert property (s_rd(`PCS_DW_CMDSTAT) |=>
    (cfg_rdata[15:0] & ~16'h006b) == 16'h0) else $error("command reserved");
  a_reset_off: assert property (!$past(nrst) |->
    !mem_enable && !io_enable) else $error("enables after reset");
endmodule
bind pcs_config_space pcs_props i_props (.clk(clk), .nrst(nrst), .cfg_req(cfg_req),
  .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
  .mem_enable(mem_enable), .io_enable(io_enable));
`default_nettype wire

// [dv/pcs_host.sv]
// Purpose: host bridge model issuing config cycles
// Assumes: one access in flight
// Notes:   released data lines carry the inverse
`default_nettype none
module pcs_host (
  input  wire logic        clk,
  input  wire logic        cfg_ack,
  input  wire logic [31:0] cfg_rdata,
  output logic             cfg_req,
  output logic             cfg_wr,
  output logic [5:0]       cfg_addr,
  output logic [3:0]       cfg_be,
  output logic [31:0]      cfg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {cfg_req, cfg_wr, cfg_addr, cfg_be, cfg_wdata} = '0;
  // One access; no answer reads as all ones
  task automatic xfer(input logic w, input logic [5:0] a, input logic [3:0] b,
                      input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cfg_req <= 1'b1;
    cfg_wr <= w;
    cfg_addr <= a;
    cfg_be <= b;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_req <= 1'b0;
    cfg_wdata <= ~d; // Stale data must not look valid
    do begin
      @(posedge clk);
      n++;
    end while (cfg_ack !== 1'b1 && n < 4);
    q = (cfg_ack === 1'b1) ? cfg_rdata : 32'hffff_ffff;
  endtask
endmodule
`default_nettype wire

// [dv/pcs_config_space_tb_top.sv]
// Purpose: self-checking bench of the config record
// Assumes: host model runs one access at a time
// Notes:   reads queued, compared at each answer
`default_nettype none
`include "pcs_defines.vh"
module pcs_config_space_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] VEN = 16'h1234; // Arbitrary value
  localparam logic [15:0] DEV = 16'h5678; // Arbitrary value
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        abort = 1'b0;
  logic        req, wr, ack, mem, io, snp, par, spc;
  logic [5:0]  addr;
  logic [3:0]  be, irq;
  logic [31:0] wdata, rdata, d, q, e;
  logic [63:0] exp_q[$];
  int          errors = 0, compares = 0, cyc = 0, i;
  always #4 clk = ~clk;
  pcs_host i_host (.clk(clk), .cfg_ack(ack), .cfg_rdata(rdata), .cfg_req(req), .cfg_wr(wr),
    .cfg_addr(addr), .cfg_be(be), .cfg_wdata(wdata));
  pcs_config_space #(.VENDOR_CODE(VEN), .DEVICE_CODE(DEV)) i_dut (.clk(clk), .nrst(nrst),
    .cfg_req(req), .cfg_wr(wr), .cfg_addr(addr), .cfg_be(be), .cfg_wdata(wdata), .cfg_ack(ack),
    .cfg_rdata(rdata), .target_abort(abort), .mem_enable(mem), .io_enable(io),
    .palette_snoop(snp), .parity_resp(par), .special_cycle(spc), .int_line(irq));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic close_out();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Writes queue a mask of zero, reads their value
  task automatic acc(input logic w, input logic [5:0] a, input logic [3:0] b,
                     input logic [31:0] dt, input logic [31:0] x);
    exp_q.push_back({w ? 32'h0 : 32'hffff_ffff, x});
    i_host.xfer(w, a, b, dt, q);
  endtask
  // Oldest note meets each answer; a hang ends the run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      errors++;
      close_out();
    end
    if (ack === 1'b1 && exp_q.size() > 0) begin
      chk("rdata", rdata & exp_q[0][63:32], exp_q[0][31:0]);
      void'(exp_q.pop_front());
    end
  end
  // Main sequence, answered even with command bits clear
  initial begin
    d = $urandom(75300);
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    acc(0, `PCS_DW_ID, 4'hf, 0, {DEV, VEN});
    acc(0, `PCS_DW_CMDSTAT, 4'hf, 0, 0);
    acc(0, `PCS_DW_CLASS, 4'hf, 0, {`PCS_CLASS_VAL, `PCS_REV_VAL});
    acc(0, `PCS_DW_HDR, 4'hf, 0, {8'h0, `PCS_HDR_TYPE, 16'h0});
    for (i = 0; i < 8; i++) begin
      d = $urandom;
      e = {16'h0, {8'h0, d[7:0]} & `PCS_CMD_RW_MASK};
      acc(1, `PCS_DW_CMDSTAT, 4'h1, d, 0);
      acc(0, `PCS_DW_CMDSTAT, 4'hf, 0, e);
      chk("enables", {spc, par, snp, mem, io}, {d[3], d[6], d[5], d[1], d[0]});
    end
    @(posedge clk);
    abort <= 1'b1;
    @(posedge clk);
    abort <= 1'b0;
    acc(1, `PCS_DW_CMDSTAT, 4'hc, 32'hf7ff_0000, 0);
    acc(0, `PCS_DW_CMDSTAT, 4'hf, 0, e | 32'h0800_0000);
    acc(1, `PCS_DW_CMDSTAT, 4'h8, 32'h08ff_ffff, 0);
    acc(0, `PCS_DW_CMDSTAT, 4'hf, 0, e);
    for (i = 4; i < 64; i++) begin
      acc(1, i[5:0], 4'hf, 32'hffff_ffff, 0);
      acc(0, i[5:0], 4'hf, 0, i == 15 ? 32'hf : (i > 15 ? 32'hffff_ffff : 32'h0));
    end
    d = $urandom;
    acc(1, 6'h20, 4'h5, d, 0);
    acc(0, 6'h20, 4'hf, 0, {8'hff, d[23:16], 8'hff, d[7:0]});
    acc(0, `PCS_DW_INTLINE, 4'hf, 0, 32'hf);
    acc(1, `PCS_DW_INTLINE, 4'hf, (q & ~32'hf) | 32'h5, 0);
    chk("int_line", irq, 4'h5);
    repeat (2) @(posedge clk);
    close_out();
  end
endmodule
`default_nettype wire
